// file: design/swr_pkg.sv
// Contract
// - Low doubleword unpack keeps destination low 32 bits and puts source low 32 bits on top.
// - High doubleword unpack moves destination high 32 bits down and puts source high 32 on top.
// - Word extract picks one of four 16-bit words by imm[1:0], zero-extended to 32 bits.
// - Word insert writes the low 16 bits of the integer or memory operand at word imm[1:0].
// - Word insert leaves the three other destination words unchanged.
// - Byte mask of a 64-bit source gathers eight byte sign bits, upper 24 bits zero.
// - Byte mask of a 128-bit source gathers sixteen byte sign bits, upper 16 bits zero.
// - The 64-bit word shuffle uses imm pairs 1:0, 3:2, 5:4, 7:6 for result words 0 to 3.
// - Each 2-bit selector picks the source word of that index, so 10 picks bits 47:32.
// - The 64-bit word shuffle takes its source from a vector register or from memory.
// - Low or high 128-bit word shuffle permutes that half and passes the other half through.
// - The doubleword shuffle routes any 32-bit source field to any result field by imm.
// - Quadword unpack joins the same low or high half of destination and source.
// - Quadword unpack ignores the unselected halves of both operands.
// - Moving a 64-bit vector into a 128-bit register writes the low half and zeroes the top.
// - Moving a 128-bit register to a 64-bit vector copies only its low 64 bits.
package swr_pkg;

  localparam int SWR_LAT_CYCLES = 1;
  localparam logic [127:0] SWR_RESET_VALUE = 128'h0;

  typedef enum logic [3:0] {
    SWR_OP_UNPACK_LOW_DWORDS,
    SWR_OP_UNPACK_HIGH_DWORDS,
    SWR_OP_EXTRACT_WORD,
    SWR_OP_INSERT_WORD,
    SWR_OP_MASK_BYTES64,
    SWR_OP_MASK_BYTES128,
    SWR_OP_SHUFFLE_WORDS64,
    SWR_OP_SHUFFLE_LOW_WORDS128,
    SWR_OP_SHUFFLE_HIGH_WORDS128,
    SWR_OP_SHUFFLE_DWORDS,
    SWR_OP_UNPACK_LOW_QWORDS,
    SWR_OP_UNPACK_HIGH_QWORDS,
    SWR_OP_MOVE_VEC64_TO_VEC128,
    SWR_OP_MOVE_VEC128_TO_VEC64
  } swr_op_e;

  typedef enum logic [1:0] {
    SWR_DST_VEC64,
    SWR_DST_VEC128,
    SWR_DST_GPR32
  } swr_dst_e;

  typedef struct packed {
    logic valid;
    swr_op_e op;
    logic [7:0] imm;
    logic use_mem;
    logic [127:0] dst;
    logic [127:0] src;
    logic [63:0] mem;
    logic [31:0] gpr;
  } swr_req_s;

  typedef struct packed {
    logic wr_en;
    swr_dst_e dst_kind;
    logic [127:0] data;
  } swr_res_s;

endpackage

// file: design/swr_unit.sv
`timescale 1ns/1ps
module swr_unit
  import swr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire swr_req_s req,
  output swr_res_s res
);

  function automatic logic [15:0] swr_pick16(input logic [63:0] v, input logic [1:0] sel);
    swr_pick16 = v[sel*16 +: 16];
  endfunction

  function automatic logic [63:0] swr_shuf4x16(input logic [63:0] v, input logic [7:0] imm);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*16 +: 16] = swr_pick16(v, imm[i*2 +: 2]);
    end
    swr_shuf4x16 = r;
  endfunction

  // Only these operations have a memory form; elsewhere use_mem is ignored so a stale
  // flag from the decoder cannot steer the wrong operand in
  function automatic logic swr_mem_form(input swr_op_e op);
    logic m;
    m = 1'b0;
    case (op)
      SWR_OP_UNPACK_LOW_DWORDS: begin
        m = 1'b1;
      end
      SWR_OP_UNPACK_HIGH_DWORDS: begin
        m = 1'b1;
      end
      SWR_OP_EXTRACT_WORD: begin
        m = 1'b0;
      end
      SWR_OP_INSERT_WORD: begin
        m = 1'b1;
      end
      SWR_OP_MASK_BYTES64: begin
        m = 1'b0;
      end
      SWR_OP_MASK_BYTES128: begin
        m = 1'b0;
      end
      SWR_OP_SHUFFLE_WORDS64: begin
        m = 1'b1;
      end
      SWR_OP_SHUFFLE_LOW_WORDS128: begin
        m = 1'b0;
      end
      SWR_OP_SHUFFLE_HIGH_WORDS128: begin
        m = 1'b0;
      end
      SWR_OP_SHUFFLE_DWORDS: begin
        m = 1'b0;
      end
      SWR_OP_UNPACK_LOW_QWORDS: begin
        m = 1'b0;
      end
      SWR_OP_UNPACK_HIGH_QWORDS: begin
        m = 1'b0;
      end
      SWR_OP_MOVE_VEC64_TO_VEC128: begin
        m = 1'b0;
      end
      SWR_OP_MOVE_VEC128_TO_VEC64: begin
        m = 1'b0;
      end
      default: begin
        m = 1'b0;
      end
    endcase
    swr_mem_form = m;
  endfunction

  wire logic take_mem = req.use_mem & swr_mem_form(req.op);
  wire logic [63:0] src64 = take_mem ? req.mem : req.src[63:0];
  wire logic [15:0] ins_word = take_mem ? req.mem[15:0] : req.gpr[15:0];

  logic [63:0] ins_vec;
  always_comb begin
    ins_vec = req.dst[63:0];
    ins_vec[req.imm[1:0]*16 +: 16] = ins_word;
  end

  logic [15:0] mask16;
  logic [127:0] dshuf;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_mask
      assign mask16[g] = req.src[g*8 + 7];
    end
    for (g = 0; g < 4; g++) begin : g_dshuf
      assign dshuf[g*32 +: 32] = req.src[req.imm[g*2 +: 2]*32 +: 32];
    end
  endgenerate

  // Operand halves, named once for the results below; the 128-bit byte mask and dword shuffle read req.src directly
  logic [63:0] src_lo;
  logic [63:0] src_hi;
  logic [63:0] dst_lo;
  logic [63:0] dst_hi;
  logic [1:0] word_sel;
  assign src_lo = req.src[63:0];
  assign src_hi = req.src[127:64];
  assign dst_lo = req.dst[63:0];
  assign dst_hi = req.dst[127:64];
  assign word_sel = req.imm[1:0];

  logic [7:0] mask8;
  generate
    for (g = 0; g < 8; g++) begin : g_mask8
      assign mask8[g] = src_lo[g*8 + 7];
    end
  endgenerate

  logic [127:0] r_unpack_low_dw;
  logic [127:0] r_unpack_high_dw;
  logic [127:0] r_extract;
  logic [127:0] r_insert;
  logic [127:0] r_mask64;
  logic [127:0] r_mask128;
  logic [127:0] r_shuf64;
  logic [127:0] r_shuf_low;
  logic [127:0] r_shuf_high;
  logic [127:0] r_shuf_dw;
  logic [127:0] r_unpack_low_qw;
  logic [127:0] r_unpack_high_qw;
  logic [127:0] r_move_wide;
  logic [127:0] r_move_narrow;

  assign r_unpack_low_dw = {64'h0, src64[31:0], dst_lo[31:0]};
  assign r_unpack_high_dw = {64'h0, src64[63:32], dst_lo[63:32]};
  assign r_extract = {112'h0, swr_pick16(src_lo, word_sel)};
  assign r_insert = {64'h0, ins_vec};
  assign r_mask64 = {120'h0, mask8};
  assign r_mask128 = {112'h0, mask16};
  assign r_shuf64 = {64'h0, swr_shuf4x16(src64, req.imm)};
  assign r_shuf_low = {src_hi, swr_shuf4x16(src_lo, req.imm)};
  assign r_shuf_high = {swr_shuf4x16(src_hi, req.imm), src_lo};
  assign r_shuf_dw = dshuf;
  assign r_unpack_low_qw = {src_lo, dst_lo};
  assign r_unpack_high_qw = {src_hi, dst_hi};
  assign r_move_wide = {64'h0, src_lo};
  assign r_move_narrow = {64'h0, src_lo};

  // Destination register file of each operation; an unknown code falls back to the
  // narrow file and is never written anyway
  function automatic swr_dst_e swr_kind_of(input swr_op_e op);
    swr_dst_e k;
    k = SWR_DST_VEC64;
    case (op)
      SWR_OP_UNPACK_LOW_DWORDS: begin
        k = SWR_DST_VEC64;
      end
      SWR_OP_UNPACK_HIGH_DWORDS: begin
        k = SWR_DST_VEC64;
      end
      SWR_OP_EXTRACT_WORD: begin
        k = SWR_DST_GPR32;
      end
      SWR_OP_INSERT_WORD: begin
        k = SWR_DST_VEC64;
      end
      SWR_OP_MASK_BYTES64: begin
        k = SWR_DST_GPR32;
      end
      SWR_OP_MASK_BYTES128: begin
        k = SWR_DST_GPR32;
      end
      SWR_OP_SHUFFLE_WORDS64: begin
        k = SWR_DST_VEC64;
      end
      SWR_OP_SHUFFLE_LOW_WORDS128: begin
        k = SWR_DST_VEC128;
      end
      SWR_OP_SHUFFLE_HIGH_WORDS128: begin
        k = SWR_DST_VEC128;
      end
      SWR_OP_SHUFFLE_DWORDS: begin
        k = SWR_DST_VEC128;
      end
      SWR_OP_UNPACK_LOW_QWORDS: begin
        k = SWR_DST_VEC128;
      end
      SWR_OP_UNPACK_HIGH_QWORDS: begin
        k = SWR_DST_VEC128;
      end
      SWR_OP_MOVE_VEC64_TO_VEC128: begin
        k = SWR_DST_VEC128;
      end
      SWR_OP_MOVE_VEC128_TO_VEC64: begin
        k = SWR_DST_VEC64;
      end
      default: begin
        k = SWR_DST_VEC64;
      end
    endcase
    swr_kind_of = k;
  endfunction

  // Bits above the destination width are forced to zero in one place
  function automatic logic [127:0] swr_width_mask(input swr_dst_e kind);
    logic [127:0] m;
    m = '0;
    case (kind)
      SWR_DST_GPR32: begin
        m = {96'h0, 32'hFFFFFFFF};
      end
      SWR_DST_VEC128: begin
        m = 128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF;
      end
      default: begin
        m = {64'h0, 64'hFFFFFFFFFFFFFFFF};
      end
    endcase
    swr_width_mask = m;
  endfunction

  // Only defined operation codes raise the write enable
  function automatic logic swr_op_known(input swr_op_e op);
    logic k;
    k = 1'b0;
    case (op)
      SWR_OP_UNPACK_LOW_DWORDS: begin
        k = 1'b1;
      end
      SWR_OP_UNPACK_HIGH_DWORDS: begin
        k = 1'b1;
      end
      SWR_OP_EXTRACT_WORD: begin
        k = 1'b1;
      end
      SWR_OP_INSERT_WORD: begin
        k = 1'b1;
      end
      SWR_OP_MASK_BYTES64: begin
        k = 1'b1;
      end
      SWR_OP_MASK_BYTES128: begin
        k = 1'b1;
      end
      SWR_OP_SHUFFLE_WORDS64: begin
        k = 1'b1;
      end
      SWR_OP_SHUFFLE_LOW_WORDS128: begin
        k = 1'b1;
      end
      SWR_OP_SHUFFLE_HIGH_WORDS128: begin
        k = 1'b1;
      end
      SWR_OP_SHUFFLE_DWORDS: begin
        k = 1'b1;
      end
      SWR_OP_UNPACK_LOW_QWORDS: begin
        k = 1'b1;
      end
      SWR_OP_UNPACK_HIGH_QWORDS: begin
        k = 1'b1;
      end
      SWR_OP_MOVE_VEC64_TO_VEC128: begin
        k = 1'b1;
      end
      SWR_OP_MOVE_VEC128_TO_VEC64: begin
        k = 1'b1;
      end
      default: begin
        k = 1'b0;
      end
    endcase
    swr_op_known = k;
  endfunction

  logic [127:0] sel_data;
  always_comb begin
    sel_data = '0;
    case (req.op)
      SWR_OP_UNPACK_LOW_DWORDS: begin
        sel_data = r_unpack_low_dw;
      end
      SWR_OP_UNPACK_HIGH_DWORDS: begin
        sel_data = r_unpack_high_dw;
      end
      SWR_OP_EXTRACT_WORD: begin
        sel_data = r_extract;
      end
      SWR_OP_INSERT_WORD: begin
        sel_data = r_insert;
      end
      SWR_OP_MASK_BYTES64: begin
        sel_data = r_mask64;
      end
      SWR_OP_MASK_BYTES128: begin
        sel_data = r_mask128;
      end
      SWR_OP_SHUFFLE_WORDS64: begin
        sel_data = r_shuf64;
      end
      SWR_OP_SHUFFLE_LOW_WORDS128: begin
        sel_data = r_shuf_low;
      end
      SWR_OP_SHUFFLE_HIGH_WORDS128: begin
        sel_data = r_shuf_high;
      end
      SWR_OP_SHUFFLE_DWORDS: begin
        sel_data = r_shuf_dw;
      end
      SWR_OP_UNPACK_LOW_QWORDS: begin
        sel_data = r_unpack_low_qw;
      end
      SWR_OP_UNPACK_HIGH_QWORDS: begin
        sel_data = r_unpack_high_qw;
      end
      SWR_OP_MOVE_VEC64_TO_VEC128: begin
        sel_data = r_move_wide;
      end
      SWR_OP_MOVE_VEC128_TO_VEC64: begin
        sel_data = r_move_narrow;
      end
      default: begin
        sel_data = '0;
      end
    endcase
  end

  swr_dst_e kind_d;
  logic wr_en_d;
  logic [127:0] data_d;
  swr_res_s res_d;
  assign kind_d = swr_kind_of(req.op);
  assign wr_en_d = req.valid & swr_op_known(req.op);
  assign data_d = sel_data & swr_width_mask(kind_d);
  assign res_d = '{wr_en: wr_en_d, dst_kind: kind_d, data: data_d};

  // One register stage so every operation has the same latency
  always_ff @(posedge clock) begin
    if (rst) begin
      res <= '{wr_en: 1'b0, dst_kind: SWR_DST_VEC64, data: SWR_RESET_VALUE};
    end else begin
      res <= res_d;
    end
  end

endmodule

// file: sim/swr_unit_props.sv
`timescale 1ns/1ps
module swr_unit_props
  import swr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire swr_req_s req,
  input wire swr_res_s res
);
  swr_req_s p_q;
  swr_op_e o;
  logic [15:0] mk;
  assign o = res.wr_en ? p_q.op : swr_op_e'(4'hF);
  always_comb for (int i = 0; i < 16; i++) mk[i] = p_q.src[8*i+7];
  always_ff @(posedge clock) p_q <= req;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_wr_one: assert property (req.valid |=> res.wr_en)
    else $error("late");
  chk_wr_idle: assert property (!req.valid |=> !res.wr_en)
    else $error("spur");
  chk_extract_word: assert property (o == SWR_OP_EXTRACT_WORD |->
    res.data == 128'(p_q.src[16*p_q.imm[1:0]+:16])) else $error("ext");
  chk_insert_word: assert property (o == SWR_OP_INSERT_WORD |->
    res.data[16*p_q.imm[1:0]+:16] == (p_q.use_mem ? p_q.mem[15:0] : p_q.gpr[15:0]))
    else $error("ins");
  chk_insert_keep: assert property (o == SWR_OP_INSERT_WORD |->
    ((res.data[63:0] ^ p_q.dst[63:0]) & ~(64'hFFFF << 16*p_q.imm[1:0])) == 0) else $error("keep");
  chk_mask_bytes: assert property (o == SWR_OP_MASK_BYTES64 |->
    res.data == 128'(mk[7:0])) else $error("mask");
  chk_unpack_low: assert property (o == SWR_OP_UNPACK_LOW_DWORDS && !p_q.use_mem |->
    res.data == {64'h0, p_q.src[31:0], p_q.dst[31:0]}) else $error("unp");
  chk_move_wide: assert property (o == SWR_OP_MOVE_VEC64_TO_VEC128 |->
    res.data == {64'h0, p_q.src[63:0]}) else $error("mov");
  cover property (o == SWR_OP_INSERT_WORD);
  cover property (o == SWR_OP_SHUFFLE_DWORDS);
  cover property (req.valid [*4]);
endmodule

// file: sim/swr_rf_model.sv
`timescale 1ns/1ps
module swr_rf_model
  import swr_pkg::*;
(
  input wire logic clock,
  input wire swr_res_s res,
  output logic [127:0] wb_q
);
  always_ff @(posedge clock) if (res.wr_en) wb_q <= res.data;
endmodule

// file: sim/swr_unit_tb.sv
`timescale 1ns/1ps
module swr_unit_tb;
  import swr_pkg::*;
  logic clock = 0;
  logic rst = 1;
  swr_req_s req;
  swr_res_s res;
  logic [127:0] wb_q, e;
  logic [127:0] dv = 128'hFFEEDDCCBBAA99887766554433221100;
  logic [127:0] sv = 128'h8001FF7F00C37E81A55A0F80F0017FFE;
  logic [63:0] mv = 64'h13579BDF2468ACE0;
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 clock = ~clock;
  swr_unit swr_unit_inst (.clock(clock), .rst(rst), .req(req), .res(res));
  swr_rf_model swr_rf_model_inst (.clock(clock), .res(res), .wb_q(wb_q));
  function automatic swr_dst_e xk(input swr_op_e op);
    case (op)
      SWR_OP_EXTRACT_WORD, SWR_OP_MASK_BYTES64, SWR_OP_MASK_BYTES128: xk = SWR_DST_GPR32;
      SWR_OP_SHUFFLE_LOW_WORDS128, SWR_OP_SHUFFLE_HIGH_WORDS128, SWR_OP_SHUFFLE_DWORDS,
        SWR_OP_UNPACK_LOW_QWORDS, SWR_OP_UNPACK_HIGH_QWORDS,
        SWR_OP_MOVE_VEC64_TO_VEC128: xk = SWR_DST_VEC128;
      default: xk = SWR_DST_VEC64;
    endcase
  endfunction
  task automatic cmp_kind(input swr_dst_e g, input swr_dst_e x);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %0t kind %0d exp %0d", $time, g, x);
    end
  endtask
  task automatic cmp(input logic [127:0] g, input logic [127:0] x);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Requests go back to back: the next one is set as the last result is read
  task automatic run(input swr_op_e op, input logic [7:0] im, input logic um,
                     input logic [127:0] x);
    req <= '{1'b1, op, im, um, dv, sv, mv, 32'hCAFEBEEF};
    @(posedge clock);
    #1 cmp(res.data, x);
    cmp(128'(res.wr_en), 128'h1);
    cmp_kind(res.dst_kind, xk(op));
  endtask
  task automatic t_low;
    run(SWR_OP_UNPACK_LOW_DWORDS, 0, 0, {64'h0, sv[31:0], dv[31:0]});
    run(SWR_OP_UNPACK_LOW_DWORDS, 0, 1, {64'h0, mv[31:0], dv[31:0]});
    run(SWR_OP_MASK_BYTES64, 0, 0, 128'h99);
    run(SWR_OP_SHUFFLE_WORDS64, 8'h1B, 0, 128'(pw(sv[63:0], 8'h1B)));
    run(SWR_OP_SHUFFLE_LOW_WORDS128, 8'h1B, 0, {sv[127:64], pw(sv[63:0], 8'h1B)});
    run(SWR_OP_UNPACK_LOW_QWORDS, 0, 0, {sv[63:0], dv[63:0]});
    run(SWR_OP_MOVE_VEC64_TO_VEC128, 0, 1, {64'h0, sv[63:0]});
  endtask
  function automatic logic [63:0] pw(input logic [63:0] v, input logic [7:0] m);
    for (int k = 0; k < 4; k++) pw[16*k+:16] = v[16*m[2*k+:2]+:16];
  endfunction
  task automatic t_word;
    for (int i = 0; i < 4; i++) begin
      e = {64'h0, dv[63:0]};
      e[16*i+:16] = i[0] ? mv[15:0] : 16'hBEEF;
      run(SWR_OP_EXTRACT_WORD, 8'hFC | 8'(i), 0, 128'(sv[16*i+:16]));
      run(SWR_OP_INSERT_WORD, 8'hFC | 8'(i), i[0], e);
    end
  endtask
  task automatic t_misc;
    run(SWR_OP_UNPACK_HIGH_DWORDS, 0, 1, {64'h0, mv[63:32], dv[63:32]});
    run(SWR_OP_UNPACK_HIGH_QWORDS, 0, 0, {sv[127:64], dv[127:64]});
    run(SWR_OP_MASK_BYTES128, 0, 0, 128'hA599);
    run(SWR_OP_SHUFFLE_WORDS64, 8'h9C, 1, 128'(pw(mv, 8'h9C)));
    run(SWR_OP_SHUFFLE_HIGH_WORDS128, 8'hE1, 0, {pw(sv[127:64], 8'hE1), sv[63:0]});
    run(SWR_OP_SHUFFLE_DWORDS, 8'h4E, 0, {sv[63:0], sv[127:64]});
    run(SWR_OP_MOVE_VEC128_TO_VEC64, 0, 0, {64'h0, sv[63:0]});
    req.valid <= 0;
    @(posedge clock);
    #1 cmp(wb_q, {64'h0, sv[63:0]});
    cmp(128'(res.wr_en), 128'h0);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    req = '0;
    repeat (20) @(posedge clock);
    #1 cmp(128'(res.wr_en), 128'h0);
    rst = 0;
    t_word;
    t_low;
    t_misc;
    finish_test;
  end
  initial begin
    #2000;
    error_cnt++;
    finish_test;
  end
endmodule
bind swr_unit swr_unit_props swr_unit_props_inst (.clock(clock), .rst(rst), .req(req), .res(res));
